// ---- dsq_drive_sequencing_fsm.sv ----
// Purpose: main sequencing state machine of a motor drive
// Assumes: all inputs except sys_rst synchronous to clk; cfg_reset is a one-cycle pulse
// Notes:   flags are registered together with the state
//
// Functional notes
// RULE1 - state is reported as code 0 disabled through 7 tripped
// RULE2 - running only in enabled; tripped only in trip-active and tripped
// RULE3 - switch-on-enable, switched-on and ready follow the state table
// RULE4 - contactor flag on in states 2 to 6, off tripped, held otherwise
// RULE5 - healthy off in trip states; returns once run and jog are off
// RULE6 - jogging rises on jog cycle start, falls on stop delay or other mode
// RULE7 - stopping during run or jog stop cycles and in fast-stop active
// RULE8 - lowest numbered satisfied exit transition wins
// RULE9 - power-up or configuration reset enters switch-on disabled
// RULE10 - transitions fire on cause rising; trip goes to trip-active
// RULE11 - disabled to start enabled when idle and no stop request
// RULE12 - coast or fast stop returns states 1 to 3 to disabled
// RULE13 - start enabled to switched on on run or jog
// RULE14 - switched on trips after 10 s without contactor closed
// RULE15 - switched on or ready back to start enabled when idle
// RULE16 - switched on to ready on contactor closed and defluxed
// RULE17 - contactor loss in ready, enabled or fast-stop is a trip
// RULE18 - ready to enabled on enable; enabled to ready on enable low
// RULE19 - enabled: coast stop to disabled, fast stop to fast-stop active
// RULE20 - enabled to start enabled when idle and stopping completed
// RULE21 - fast-stop exits on timer, coast mode or zero setpoint
// RULE22 - trip-active to tripped on quench; reset edge clears tripped
`timescale 1ns/1ps

module dsq_drive_sequencing_fsm
    import dsq_pkg::*;
#(
    parameter int CONT_TMO_CYC = DSQ_CONT_TMO_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cfg_reset,
    input  wire dsq_cmd_t   cmd,
    output logic [2:0]      seq_state,
    output dsq_flags_t      flags
);

    ////////////////////////////////////////////////////////////////////////
    // state and combinational terms
    dsq_regs_t                  r_r;
    dsq_regs_t                  r_nxt;
    logic [DSQ_TR_HI:DSQ_TR_LO] cause;
    logic [DSQ_TR_HI:DSQ_TR_LO] fire;
    logic                       idle;
    logic                       halt;
    logic                       loss;
    logic                       tmo;
    logic                       trst_rise;
    dsq_state_t                 s;

    localparam logic [DSQ_TMR_W-1:0] TMO_LIM = DSQ_TMR_W'(CONT_TMO_CYC);

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        r_nxt     = r_r;
        idle      = ~cmd.run & ~cmd.jog;
        halt      = ~cmd.not_coast_stop | ~cmd.not_fast_stop;
        loss      = ~cmd.contactor_closed;
        tmo       = (r_r.tmr == TMO_LIM);
        trst_rise = cmd.trip_reset & ~r_r.trst_prev;

        // cause of each transition, indexed by its number
        cause     = '0;
        cause[2]  = cmd.trip;                                       // [RULE10]
        cause[3]  = idle & cmd.not_fast_stop & cmd.not_coast_stop;  // [RULE11]
        cause[4]  = cmd.trip;                                       // [RULE10]
        cause[5]  = halt;                                           // [RULE12]
        cause[6]  = cmd.run | cmd.jog;                              // [RULE13]
        cause[7]  = cmd.trip | tmo;                                 // [RULE14]
        cause[8]  = halt;                                           // [RULE12]
        cause[9]  = idle;                                           // [RULE15]
        cause[10] = cmd.contactor_closed & cmd.defluxed;            // [RULE16]
        cause[11] = cmd.trip | loss;                                // [RULE17]
        cause[12] = halt;                                           // [RULE12]
        cause[13] = idle;                                           // [RULE15]
        cause[14] = cmd.enable;                                     // [RULE18]
        cause[15] = cmd.trip | loss;                                // [RULE17]
        cause[16] = ~cmd.not_coast_stop;                            // [RULE19]
        cause[17] = ~cmd.not_fast_stop;                             // [RULE19]
        cause[18] = idle & cmd.stop_done;                           // [RULE20]
        cause[19] = ~cmd.enable;                                    // [RULE18]
        cause[20] = cmd.trip | loss;                                // [RULE17]
        cause[21] = cmd.fstop_timer_done | cmd.fstop_mode_coast
                  | cmd.zero_setpoint;                              // [RULE21]
        cause[22] = cmd.stack_quenched;                             // [RULE22]
        cause[23] = ~cmd.trip & trst_rise;                          // [RULE22]

        // only a cause that has just become true counts
        fire = cause & ~r_r.cause_prev;                             // [RULE10]

        // each chain is in transition-number order
        unique case (r_r.state)                                     // [RULE8]
            DSQ_ST_DISABLED: begin
                if (fire[2]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[3]) begin
                    r_nxt.state = DSQ_ST_START_EN;
                end
            end
            DSQ_ST_START_EN: begin
                if (fire[4]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[5]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end else if (fire[6]) begin
                    r_nxt.state = DSQ_ST_SWITCHED_ON;
                end
            end
            DSQ_ST_SWITCHED_ON: begin
                if (fire[7]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[8]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end else if (fire[9]) begin
                    r_nxt.state = DSQ_ST_START_EN;
                end else if (fire[10]) begin
                    r_nxt.state = DSQ_ST_READY;
                end
            end
            DSQ_ST_READY: begin
                if (fire[11]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[12]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end else if (fire[13]) begin
                    r_nxt.state = DSQ_ST_START_EN;
                end else if (fire[14]) begin
                    r_nxt.state = DSQ_ST_ENABLED;
                end
            end
            DSQ_ST_ENABLED: begin
                if (fire[15]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[16]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end else if (fire[17]) begin
                    r_nxt.state = DSQ_ST_FSTOP;
                end else if (fire[18]) begin
                    r_nxt.state = DSQ_ST_START_EN;
                end else if (fire[19]) begin
                    r_nxt.state = DSQ_ST_READY;
                end
            end
            DSQ_ST_FSTOP: begin
                if (fire[20]) begin
                    r_nxt.state = DSQ_ST_TRIP_ACT;
                end else if (fire[21]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end
            end
            DSQ_ST_TRIP_ACT: begin
                if (fire[22]) begin
                    r_nxt.state = DSQ_ST_TRIPPED;
                end
            end
            DSQ_ST_TRIPPED: begin
                if (fire[23]) begin
                    r_nxt.state = DSQ_ST_DISABLED;
                end
            end
        endcase

        // configuration restore or leaving config mode beats everything
        if (cfg_reset) begin
            r_nxt.state = DSQ_ST_DISABLED;                          // [RULE9]
        end
        s = r_nxt.state;

        // causes restart on entry so one already true at entry still fires
        if (s == r_r.state && !cfg_reset) begin
            r_nxt.cause_prev = cause;
        end else begin
            r_nxt.cause_prev = '0;
        end
        r_nxt.trst_prev = cmd.trip_reset;
        r_nxt.run_prev  = cmd.run;
        r_nxt.jog_prev  = cmd.jog;

        // contactor watchdog, saturates at the limit
        if (r_r.state == DSQ_ST_SWITCHED_ON && loss) begin
            if (!tmo) begin
                r_nxt.tmr = DSQ_TMR_W'(r_r.tmr + 1'b1);             // [RULE14]
            end
        end else begin
            r_nxt.tmr = DSQ_TMR_RST;
        end

        // jog cycle, only while staying enabled
        if (s != DSQ_ST_ENABLED) begin
            r_nxt.flags.jogging = 1'b0;                             // [RULE6]
        end else if (r_r.flags.jogging) begin
            // stop delay over, or run demanded as another mode
            if (cmd.jog_stop_done || cmd.run) begin
                r_nxt.flags.jogging = 1'b0;                         // [RULE6]
            end
        end else if (cmd.jog && !r_r.jog_prev && !cmd.run) begin
            r_nxt.flags.jogging = 1'b1;                             // [RULE6]
        end

        // stopping cycle after run falls or an active jog is released
        if (s != DSQ_ST_ENABLED || cmd.stop_done) begin
            r_nxt.stop_cyc = 1'b0;
        end else if ((r_r.run_prev && !cmd.run)
                  || (r_r.flags.jogging && r_r.jog_prev && !cmd.jog)) begin
            r_nxt.stop_cyc = 1'b1;                                  // [RULE7]
        end

        // flags follow the next state so they line up with seq_state
        r_nxt.flags.tripped  = (s == DSQ_ST_TRIP_ACT)
                             || (s == DSQ_ST_TRIPPED);              // [RULE2]
        r_nxt.flags.running  = (s == DSQ_ST_ENABLED);               // [RULE2]
        r_nxt.flags.stopping = (s == DSQ_ST_FSTOP)
                             || (s == DSQ_ST_ENABLED && r_nxt.stop_cyc); // [RULE7]
        r_nxt.flags.switch_on_enable = (s != DSQ_ST_DISABLED)
                                    && (s != DSQ_ST_TRIPPED);       // [RULE3]
        r_nxt.flags.switched_on = (s >= DSQ_ST_SWITCHED_ON)
                               && (s <= DSQ_ST_TRIP_ACT);           // [RULE3]
        r_nxt.flags.ready    = (s >= DSQ_ST_READY)
                            && (s <= DSQ_ST_TRIP_ACT);              // [RULE3]

        // states 0 and 1 keep whatever the contactor flag was
        unique case (s)
            DSQ_ST_DISABLED,
            DSQ_ST_START_EN: r_nxt.flags.out_contactor = r_r.flags.out_contactor; // [RULE4]
            DSQ_ST_TRIPPED:  r_nxt.flags.out_contactor = 1'b0;      // [RULE4]
            default:         r_nxt.flags.out_contactor = 1'b1;      // [RULE4]
        endcase

        // in tripped healthy latches once run and jog are both off
        unique case (s)
            DSQ_ST_TRIP_ACT: r_nxt.flags.healthy = 1'b0;            // [RULE5]
            DSQ_ST_TRIPPED: begin
                r_nxt.flags.healthy = (r_r.state == DSQ_ST_TRIPPED
                                       && r_r.flags.healthy) || idle; // [RULE5]
            end
            default:         r_nxt.flags.healthy = 1'b1;            // [RULE5]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_r.state      <= DSQ_ST_DISABLED;                      // [RULE9]
            r_r.cause_prev <= '0;
            r_r.trst_prev  <= 1'b0;
            r_r.run_prev   <= 1'b0;
            r_r.jog_prev   <= 1'b0;
            r_r.stop_cyc   <= 1'b0;
            r_r.tmr        <= DSQ_TMR_RST;
            r_r.flags      <= DSQ_FLAGS_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign seq_state = r_r.state;                                   // [RULE1]
    assign flags     = r_r.flags;

endmodule : dsq_drive_sequencing_fsm

// ---- dsq_pkg.sv ----
// Purpose: shared types and constants of the drive sequencing state machine
// Assumes: 40 MHz system clock
// Notes:   state codes follow declaration order, 0 to 7
package dsq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // main sequencing states, code 0 to 7 in this order
    typedef enum logic [2:0] {
        DSQ_ST_DISABLED,
        DSQ_ST_START_EN,
        DSQ_ST_SWITCHED_ON,
        DSQ_ST_READY,
        DSQ_ST_ENABLED,
        DSQ_ST_FSTOP,
        DSQ_ST_TRIP_ACT,
        DSQ_ST_TRIPPED
    } dsq_state_t;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int DSQ_CLK_HZ       = 40_000_000;
    localparam int DSQ_CONT_TMO_S   = 10;
    localparam int DSQ_CONT_TMO_CYC = DSQ_CONT_TMO_S * DSQ_CLK_HZ;
    localparam int DSQ_TMR_W        = 29;

    // transition numbers carried in the cause vector
    localparam int DSQ_TR_LO = 2;
    localparam int DSQ_TR_HI = 23;

    ////////////////////////////////////////////////////////////////////////
    // control inputs, active high except not_coast_stop and not_fast_stop, which are active low
    typedef struct packed {
        logic run;
        logic jog;
        logic not_coast_stop;
        logic not_fast_stop;
        logic enable;
        logic trip;
        logic trip_reset;
        logic contactor_closed;
        logic defluxed;
        logic stack_quenched;
        logic fstop_timer_done;
        logic fstop_mode_coast;
        logic zero_setpoint;
        logic stop_done;
        logic jog_stop_done;
    } dsq_cmd_t;

    // state flags
    typedef struct packed {
        logic tripped;
        logic running;
        logic jogging;
        logic stopping;
        logic out_contactor;
        logic switch_on_enable;
        logic switched_on;
        logic ready;
        logic healthy;
    } dsq_flags_t;

    // after reset only healthy is set
    localparam dsq_flags_t DSQ_FLAGS_RST = 9'h001;

    ////////////////////////////////////////////////////////////////////////
    // whole register state of the sequencer
    typedef struct packed {
        dsq_state_t                     state;
        logic [DSQ_TR_HI:DSQ_TR_LO]     cause_prev;
        logic                           trst_prev;
        logic                           run_prev;
        logic                           jog_prev;
        logic                           stop_cyc;
        logic [DSQ_TMR_W-1:0]           tmr;
        dsq_flags_t                     flags;
    } dsq_regs_t;

    localparam logic [DSQ_TMR_W-1:0] DSQ_TMR_RST = 29'h0000_0000;

endpackage : dsq_pkg

// ---- dsq_seq_asserts.sv ----
// Purpose: port-level property checks of the drive sequencer
// Assumes: one clock, sys_rst asynchronous active high
// Notes:   flags and seq_state are registered on the same edge
`timescale 1ns/1ps
module dsq_seq_asserts
    import dsq_pkg::*;
#(
    parameter int CONT_TMO_CYC = DSQ_CONT_TMO_CYC
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cfg_reset,
    input wire dsq_cmd_t   cmd,
    input wire logic [2:0] seq_state,
    input wire dsq_flags_t flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // cycles spent switched on with the contactor still open
    logic [31:0] open_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            open_r <= 32'h0000_0000;
        end else if (seq_state == 3'h2 && !cmd.contactor_closed) begin
            open_r <= open_r + 32'h0000_0001;
        end else begin
            open_r <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_run_state: assert property (flags.running == (seq_state == 3'h4))
        else $error("running flag out of step with state");
    chk_trip_flag: assert property (flags.tripped == (seq_state >= 3'h6))
        else $error("tripped flag out of step with state");
    chk_soe_state: assert property (flags.switch_on_enable == (seq_state != 3'h0 && seq_state != 3'h7))
        else $error("switch on enable flag wrong");
    chk_ready_span: assert property (flags.ready == (seq_state inside {[3'h3:3'h6]})
        && flags.switched_on == (seq_state inside {[3'h2:3'h6]})) else $error("ready or switched on flag wrong");
    chk_contact_on: assert property (seq_state >= 3'h2 |-> flags.out_contactor == (seq_state != 3'h7))
        else $error("contactor flag wrong");
    chk_contact_hold: assert property (seq_state <= 3'h1 |-> $stable(flags.out_contactor))
        else $error("contactor flag not held");
    chk_health_trip: assert property (seq_state != 3'h7 |-> flags.healthy == (seq_state != 3'h6))
        else $error("healthy flag wrong");
    chk_jog_state: assert property (flags.jogging |-> seq_state == 3'h4)
        else $error("jogging outside enabled");
    chk_stop_state: assert property ((seq_state == 3'h4) || flags.stopping == (seq_state == 3'h5))
        else $error("stopping flag wrong");
    chk_cfg_home: assert property (cfg_reset |=> seq_state == 3'h0)
        else $error("configuration reset did not disable");
    chk_trip_entry: assert property ($rose(cmd.trip) && seq_state <= 3'h5 && !cfg_reset |=> seq_state == 3'h6)
        else $error("trip did not enter trip active");
    chk_cont_wait: assert property (open_r <= 32'(CONT_TMO_CYC + 3))
        else $error("contactor timeout overran");
    chk_loss_trip: assert property (seq_state inside {[3'h3:3'h5]} && !cmd.contactor_closed && !cfg_reset
        |=> seq_state == 3'h6) else $error("contactor loss did not trip");
    chk_trip_hold: assert property (seq_state == 3'h7 && !cfg_reset && (cmd.trip || !$rose(cmd.trip_reset))
        |=> seq_state == 3'h7) else $error("left tripped without reset edge");

    cov_jogging: cover property (flags.jogging && flags.stopping);
    cov_fstop: cover property (seq_state == 3'h5);
    cov_tripped: cover property (seq_state == 3'h7 && flags.healthy);
endmodule : dsq_seq_asserts

bind dsq_drive_sequencing_fsm dsq_seq_asserts #(.CONT_TMO_CYC(CONT_TMO_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .cfg_reset(cfg_reset), .cmd(cmd), .seq_state(seq_state), .flags(flags));

// ---- dsq_plant_model.sv ----
// Purpose: contactor and power stack seen by the sequencer
// Assumes: contacts close three cycles after the coil is demanded
// Notes:   close_en low models contacts that never close or drop out
`timescale 1ns/1ps
module dsq_plant_model
    import dsq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire dsq_flags_t flags,
    input  wire logic       close_en,
    output logic            contactor_closed,
    output logic            defluxed,
    output logic            stack_quenched
);
    logic [2:0] coil_r;
    logic [1:0] quench_r;
    // contacts open at once on close_en low, so a loss trips promptly
    assign contactor_closed = coil_r[2] & close_en;
    assign stack_quenched   = quench_r[1];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            coil_r   <= 3'h0;
            quench_r <= 2'h0;
            defluxed <= 1'b0;
        end else begin
            coil_r   <= {coil_r[1:0], flags.out_contactor & close_en};
            quench_r <= {quench_r[0], flags.tripped};
            defluxed <= contactor_closed;
        end
    end
endmodule : dsq_plant_model

// ---- drive_sequencing_fsm_tb_top.sv ----
// Purpose: directed walk through the sequencer states
// Assumes: inputs change at the falling edge
// Notes:   contactor timeout shortened to TMO cycles
`timescale 1ns/1ps
module drive_sequencing_fsm_tb_top;
    import dsq_pkg::*;
    localparam int TMO = 20;
    logic       clk, sys_rst, cfg_reset, close_en, cc, dfx, sq;
    dsq_cmd_t   tb_cmd, cmd;
    logic [2:0] seq_state;
    dsq_flags_t flags;
    int         errors, checks;

    always_comb begin
        cmd = tb_cmd;
        cmd.contactor_closed = cc;
        cmd.defluxed = dfx;
        cmd.stack_quenched = sq;
    end
    dsq_drive_sequencing_fsm #(.CONT_TMO_CYC(TMO)) uut (.clk(clk), .sys_rst(sys_rst), .cfg_reset(cfg_reset),
        .cmd(cmd), .seq_state(seq_state), .flags(flags));
    dsq_plant_model u_plant (.clk(clk), .sys_rst(sys_rst), .flags(flags), .close_en(close_en),
        .contactor_closed(cc), .defluxed(dfx), .stack_quenched(sq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic cmp_state(input logic [2:0] exp);
        checks++;
        if (seq_state !== exp) begin
            errors++;
            $display("unexpected state at %0t: %h vs %h", $time, seq_state, exp);
        end
    endtask : cmp_state
    task automatic cmp_flags(input dsq_flags_t exp);
        checks++;
        if (flags !== exp) begin
            errors++;
            $display("unexpected flags at %0t: %h vs %h", $time, flags, exp);
        end
    endtask : cmp_flags
    // bounded wait, then compare
    task automatic wait_state(input logic [2:0] exp);
        for (int i = 0; i < 40 && seq_state !== exp; i++) step(1);
        cmp_state(exp);
    endtask : wait_state
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checks = 0;
        sys_rst = 1'b1;
        cfg_reset = 1'b0;
        close_en = 1'b1;
        tb_cmd = '0;
        tb_cmd.not_coast_stop = 1'b1;
        tb_cmd.not_fast_stop = 1'b1;
        step(20);
        cmp_flags(9'h001);
        sys_rst = 1'b0;
        wait_state(3'h1);
        cmp_flags(9'h009);
        tb_cmd.run = 1'b1;
        wait_state(3'h2);
        wait_state(3'h3);
        cmp_flags(9'h01F);
        // coast stop and enable together: the lower number wins
        tb_cmd.enable = 1'b1;
        tb_cmd.not_coast_stop = 1'b0;
        step(1);
        cmp_state(3'h0);
        cmp_flags(9'h011);
        tb_cmd.run = 1'b0;
        tb_cmd.enable = 1'b0;
        tb_cmd.not_coast_stop = 1'b1;
        wait_state(3'h1);
        tb_cmd.run = 1'b1;
        wait_state(3'h3);
        tb_cmd.run = 1'b0;
        wait_state(3'h1);
        tb_cmd.run = 1'b1;
        wait_state(3'h3);
        tb_cmd.enable = 1'b1;
        wait_state(3'h4);
        cmp_flags(9'h09F);
        tb_cmd.run = 1'b0;
        step(1);
        cmp_flags(9'h0BF);
        tb_cmd.stop_done = 1'b1;
        wait_state(3'h1);
        tb_cmd.stop_done = 1'b0;
        tb_cmd.enable = 1'b0;
        tb_cmd.jog = 1'b1;
        wait_state(3'h3);
        tb_cmd.enable = 1'b1;
        wait_state(3'h4);
        tb_cmd.jog = 1'b0;
        step(1);
        tb_cmd.jog = 1'b1;
        step(1);
        cmp_flags(9'h0DF);
        tb_cmd.jog = 1'b0;
        step(1);
        cmp_flags(9'h0FF);
        tb_cmd.jog_stop_done = 1'b1;
        step(1);
        cmp_flags(9'h0BF);
        tb_cmd.jog_stop_done = 1'b0;
        tb_cmd.not_fast_stop = 1'b0;
        step(1);
        cmp_state(3'h5);
        cmp_flags(9'h03F);
        tb_cmd.zero_setpoint = 1'b1;
        step(1);
        cmp_state(3'h0);
        tb_cmd.zero_setpoint = 1'b0;
        tb_cmd.not_fast_stop = 1'b1;
        wait_state(3'h1);
        tb_cmd.trip = 1'b1;
        step(1);
        cmp_state(3'h6);
        cmp_flags(9'h11E);
        wait_state(3'h7);
        step(2);
        cmp_flags(9'h101);
        tb_cmd.trip_reset = 1'b1;
        step(2);
        cmp_state(3'h7);
        tb_cmd.trip = 1'b0;
        tb_cmd.trip_reset = 1'b0;
        step(1);
        tb_cmd.trip_reset = 1'b1;
        step(1);
        cmp_state(3'h0);
        // contacts never close while switched on
        wait_state(3'h1);
        close_en = 1'b0;
        tb_cmd.run = 1'b1;
        wait_state(3'h2);
        step(TMO / 2);
        cmp_state(3'h2);
        wait_state(3'h6);
        wait_state(3'h7);
        tb_cmd.run = 1'b0;
        tb_cmd.trip_reset = 1'b0;
        step(1);
        tb_cmd.trip_reset = 1'b1;
        wait_state(3'h0);
        close_en = 1'b1;
        wait_state(3'h1);
        tb_cmd.run = 1'b1;
        wait_state(3'h4);
        close_en = 1'b0;
        step(1);
        cmp_state(3'h6);
        cfg_reset = 1'b1;
        step(1);
        cfg_reset = 1'b0;
        cmp_state(3'h0);
        // coast stop straight out of enabled
        close_en = 1'b1;
        tb_cmd.run = 1'b0;
        wait_state(3'h1);
        tb_cmd.run = 1'b1;
        wait_state(3'h4);
        tb_cmd.not_coast_stop = 1'b0;
        step(1);
        cmp_state(3'h0);
        // fast stop left through the coast-mode exit
        tb_cmd.not_coast_stop = 1'b1;
        tb_cmd.run = 1'b0;
        wait_state(3'h1);
        tb_cmd.run = 1'b1;
        wait_state(3'h4);
        tb_cmd.not_fast_stop = 1'b0;
        step(1);
        cmp_state(3'h5);
        tb_cmd.fstop_mode_coast = 1'b1;
        step(1);
        cmp_state(3'h0);
        tb_cmd.fstop_mode_coast = 1'b0;
        tb_cmd.not_fast_stop = 1'b1;
        print_verdict();
    end
endmodule : drive_sequencing_fsm_tb_top
